/* File: hw/acr_map.svh */
/*
 Register offsets, reset values, field positions and sizes of the lower
 accelerometer register map.
 Assumes inclusion by bare name from the files under hw/.
*/
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

`define ACR_ADDR_STATUS 8'h00
`define ACR_ADDR_X_HIGH 8'h01
`define ACR_ADDR_X_LOW 8'h02
`define ACR_ADDR_Y_HIGH 8'h03
`define ACR_ADDR_Y_LOW 8'h04
`define ACR_ADDR_Z_HIGH 8'h05
`define ACR_ADDR_Z_LOW 8'h06
`define ACR_ADDR_BUFFER_SETUP 8'h09
`define ACR_ADDR_BUFFER_TRIGGER_MAP 8'h0a
`define ACR_ADDR_SYSTEM_MODE_NOW 8'h0b
`define ACR_ADDR_INTERRUPT_SOURCE 8'h0c
`define ACR_ADDR_DEVICE_IDENTITY 8'h0d
`define ACR_ADDR_RANGE_CONFIG 8'h0e
`define ACR_ADDR_HIGHPASS_CUTOFF 8'h0f
`define ACR_ADDR_ORIENTATION_STATE 8'h10
`define ACR_ADDR_ORIENTATION_CONFIG 8'h11
`define ACR_ADDR_ORIENTATION_DEBOUNCE 8'h12
`define ACR_ADDR_BACKFRONT_ZLOCK 8'h13
`define ACR_ADDR_ORIENTATION_THS 8'h14
`define ACR_ADDR_FALL_CONFIG 8'h15
`define ACR_ADDR_FALL_SOURCE 8'h16
`define ACR_ADDR_FALL_THRESHOLD 8'h17
`define ACR_ADDR_FALL_DEBOUNCE 8'h18

`define ACR_RESET_ZERO 8'h00
`define ACR_RESET_ORIENTATION_CONFIG 8'h80
`define ACR_RESET_BACKFRONT_ZLOCK 8'h44
`define ACR_RESET_ORIENTATION_THS 8'h84

`define ACR_BUFFER_OPERATING_SELECT_HI 7
`define ACR_BUFFER_OPERATING_SELECT_LO 6
`define ACR_WATERMARK_HI 5
`define ACR_WATERMARK_LO 0
`define ACR_STATUS_OVERRUN 7
`define ACR_STATUS_READY 3

`define ACR_BYTES_PER_SAMPLE 3'd6
`define ACR_LAST_BYTE 3'd5
`define ACR_LAST_FAST_BYTE 3'd4

`endif

/* File: hw/acr_pkg.sv */
/*
 Types shared by the accelerometer register bank files.
 Assumes nothing of its surroundings.
*/
package acr_pkg;

  typedef enum logic [1:0] {
    ACR_FIFO_OFF,
    ACR_FIFO_CIRCULAR,
    ACR_FIFO_STOP,
    ACR_FIFO_TRIGGER
  } acr_buffer_operating_select_type;

endpackage : acr_pkg

/* File: hw/acr_sample_mem.sv */
/*
 Small sample store for buffered XYZ samples; read data are registered.
 Assumes one clock and a write port and read port driven by the bank.
*/
`timescale 1ns/1ps
`default_nettype none

module acr_sample_mem #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : acr_sample_mem

`default_nettype wire

/* File: hw/acr_next_addr.sv */
/*
 Burst auto-increment address of the lower register map.
 Assumes the buffer and fast-read selections come from the register bank.
*/
`timescale 1ns/1ps
`default_nettype none

module acr_next_addr
  import acr_pkg::*;
(
  input wire logic [7:0] addr,
  input wire logic fifo_on,
  input wire logic fast_read,
  output logic [7:0] next_addr
);

  `include "acr_map.svh"

  always_comb begin
    unique case (addr)
      `ACR_ADDR_STATUS: next_addr = `ACR_ADDR_X_HIGH;
      `ACR_ADDR_X_HIGH: begin
        if (fifo_on) begin
          next_addr = `ACR_ADDR_X_HIGH;
        end else if (fast_read) begin
          next_addr = `ACR_ADDR_Y_HIGH;
        end else begin
          next_addr = `ACR_ADDR_X_LOW;
        end
      end
      `ACR_ADDR_X_LOW: next_addr = fast_read ? `ACR_ADDR_STATUS : `ACR_ADDR_Y_HIGH;
      `ACR_ADDR_Y_HIGH: begin
        if (!fast_read) begin
          next_addr = `ACR_ADDR_Y_LOW;
        end else if (fifo_on) begin
          next_addr = `ACR_ADDR_STATUS;
        end else begin
          next_addr = `ACR_ADDR_Z_HIGH;
        end
      end
      `ACR_ADDR_Y_LOW: next_addr = fast_read ? `ACR_ADDR_STATUS : `ACR_ADDR_Z_HIGH;
      `ACR_ADDR_Z_HIGH: next_addr = fast_read ? `ACR_ADDR_STATUS : `ACR_ADDR_Z_LOW;
      `ACR_ADDR_Z_LOW: next_addr = `ACR_ADDR_STATUS;
      default: next_addr = 8'(addr + 8'h01);
    endcase
  end

endmodule : acr_next_addr

`default_nettype wire

/* File: hw/acr_regs.sv */
/*
 Lower register bank of a three-axis accelerometer: status, sample output,
 sample buffer, configuration and event source registers, with burst
 auto-increment addressing.
 Assumes a byte-level access port from a serial protocol engine on the
 same clock, and sample and event producers on the same clock.
*/
// Functional notes
// - Address 0x00 reads real-time status with the buffer off and buffer status otherwise.
// - Each axis puts sample bits 11:4 in its high register and bits 3:0 in bits 7:4 of its low register.
// - With the buffer on, the X high register reads buffered XYZ data and bursts wrap to 0x01.
// - Fast read with buffer off goes X high to 0x03, Y high to 0x05, Z high to 0x00; with buffer on Y and Z high go to 0x00.
// - Without fast read bursts step by one up to 0x06 then wrap to 0x00; fast read sends low registers to 0x00.
// - A bus stop condition clears the held burst address.
// - Standby-only configuration registers take writes only in standby.
// - Writing an any-mode threshold or debounce register restarts its debounce counter.
// - Status and output registers clear on entry to active mode and hold on return to standby.
`timescale 1ns/1ps
`default_nettype none

module acr_regs
  import acr_pkg::*;
#(
  parameter logic [7:0] IDENTITY = 8'h5c, // Arbitrary identity value
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic ADDR_LOAD,
  input wire logic [7:0] ADDR_IN,
  input wire logic WR_STB,
  input wire logic [7:0] WR_DATA,
  input wire logic RD_STB,
  input wire logic STOP_DET,
  input wire logic FAST_READ,
  input wire logic ACTIVE_MODE,
  input wire logic SAMPLE_STB,
  input wire logic [11:0] SAMPLE_X,
  input wire logic [11:0] SAMPLE_Y,
  input wire logic [11:0] SAMPLE_Z,
  input wire logic SRC_STB,
  input wire logic [7:0] INT_SOURCE_IN,
  input wire logic [7:0] ORIENT_STATE_IN,
  input wire logic [7:0] FALL_SOURCE_IN,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic [7:0] BUFFER_SETUP,
  output logic [7:0] BUFFER_TRIGGER_MAP,
  output logic [7:0] RANGE_CONFIG,
  output logic [7:0] HIGHPASS_CUTOFF,
  output logic [7:0] ORIENT_CONFIG,
  output logic [7:0] ORIENT_DEBOUNCE,
  output logic [7:0] BACKFRONT_ZLOCK,
  output logic [7:0] ORIENT_THS,
  output logic [7:0] FALL_CONFIG,
  output logic [7:0] FALL_THRESHOLD,
  output logic [7:0] FALL_DEBOUNCE,
  output logic ORIENT_COUNT_CLR,
  output logic FALL_COUNT_CLR
);

  `include "acr_map.svh"

  logic [7:0] addr_ptr;
  logic [7:0] next_addr;
  logic active_q;
  logic activate;
  acr_buffer_operating_select_type buffer_operating_select;
  logic fifo_on;
  logic [11:0] x_sample, y_sample, z_sample;
  logic [7:0] rt_status;
  logic [7:0] int_source, orient_state, fall_source;
  logic [AW-1:0] wr_ptr, rd_ptr;
  logic [AW:0] fifo_count;
  logic fifo_overflow;
  logic fifo_full, fifo_empty, fifo_push, fifo_drop_oldest, fifo_pop;
  logic [2:0] byte_idx;
  logic [35:0] head_sample;
  logic [7:0] read_value;
  logic [7:0] fifo_status;
  logic wr_ok;

  // Byte k of a sample: even k is an axis high byte, odd k its low nibble
  function automatic logic [7:0] sample_byte(input logic [35:0] s, input logic [2:0] k);
    logic [11:0] axis;
    axis = (k < 3'd2) ? s[35:24] : ((k < 3'd4) ? s[23:12] : s[11:0]);
    return k[0] ? {axis[3:0], 4'h0} : axis[11:4];
  endfunction : sample_byte

  // Registers that take writes in either mode
  function automatic logic any_mode_reg(input logic [7:0] a);
    return (a == `ACR_ADDR_BUFFER_SETUP) || (a == `ACR_ADDR_HIGHPASS_CUTOFF) ||
           (a == `ACR_ADDR_ORIENTATION_DEBOUNCE) || (a == `ACR_ADDR_FALL_THRESHOLD) ||
           (a == `ACR_ADDR_FALL_DEBOUNCE);
  endfunction : any_mode_reg

  // Registers that take writes only in standby
  function automatic logic standby_reg(input logic [7:0] a);
    return (a == `ACR_ADDR_BUFFER_TRIGGER_MAP) || (a == `ACR_ADDR_RANGE_CONFIG) ||
           (a == `ACR_ADDR_ORIENTATION_CONFIG) || (a == `ACR_ADDR_BACKFRONT_ZLOCK) ||
           (a == `ACR_ADDR_ORIENTATION_THS) || (a == `ACR_ADDR_FALL_CONFIG);
  endfunction : standby_reg

  assign buffer_operating_select = acr_buffer_operating_select_type'(BUFFER_SETUP[`ACR_BUFFER_OPERATING_SELECT_HI:`ACR_BUFFER_OPERATING_SELECT_LO]);
  assign fifo_on = (buffer_operating_select != ACR_FIFO_OFF);
  assign activate = ACTIVE_MODE && !active_q;
  assign wr_ok = any_mode_reg(addr_ptr) || (standby_reg(addr_ptr) && !active_q);
  assign fifo_full = (fifo_count == (AW+1)'(DEPTH));
  assign fifo_empty = (fifo_count == '0);
  assign fifo_push = SAMPLE_STB && fifo_on && (!fifo_full || buffer_operating_select == ACR_FIFO_CIRCULAR);
  assign fifo_drop_oldest = SAMPLE_STB && fifo_on && fifo_full && buffer_operating_select == ACR_FIFO_CIRCULAR;
  assign fifo_pop = RD_STB && fifo_on && addr_ptr == `ACR_ADDR_X_HIGH && !fifo_empty &&
                    byte_idx == (FAST_READ ? `ACR_LAST_FAST_BYTE : `ACR_LAST_BYTE);
  assign fifo_status = {fifo_overflow,
                        (BUFFER_SETUP[`ACR_WATERMARK_HI:`ACR_WATERMARK_LO] != 6'h00) &&
                        (fifo_count >= BUFFER_SETUP[`ACR_WATERMARK_HI:`ACR_WATERMARK_LO]),
                        fifo_count};

  acr_next_addr u_next_addr (
    .addr(addr_ptr),
    .fifo_on(fifo_on),
    .fast_read(FAST_READ),
    .next_addr(next_addr)
  );

  acr_sample_mem #(
    .WIDTH(36),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_sample_mem (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .wr_en(fifo_push),
    .wr_addr(wr_ptr),
    .wr_data({SAMPLE_X, SAMPLE_Y, SAMPLE_Z}),
    .rd_addr(rd_ptr),
    .rd_data(head_sample)
  );

  // Burst address pointer
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      addr_ptr <= 8'h00;
    end else if (STOP_DET) begin
      addr_ptr <= 8'h00;
    end else if (ADDR_LOAD) begin
      addr_ptr <= ADDR_IN;
    end else if (RD_STB) begin
      addr_ptr <= next_addr;
    end else if (WR_STB) begin
      addr_ptr <= 8'(addr_ptr + 8'h01);
    end
  end

  // Mode tracking
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      active_q <= 1'b0;
    end else begin
      active_q <= ACTIVE_MODE;
    end
  end

  // Read mux
  always_comb begin
    unique case (addr_ptr)
      `ACR_ADDR_STATUS: read_value = fifo_on ? fifo_status : rt_status;
      `ACR_ADDR_X_HIGH: begin
        if (fifo_on) begin
          read_value = fifo_empty ? 8'h00 : sample_byte(head_sample, byte_idx);
        end else begin
          read_value = x_sample[11:4];
        end
      end
      `ACR_ADDR_X_LOW: read_value = {x_sample[3:0], 4'h0};
      `ACR_ADDR_Y_HIGH: read_value = y_sample[11:4];
      `ACR_ADDR_Y_LOW: read_value = {y_sample[3:0], 4'h0};
      `ACR_ADDR_Z_HIGH: read_value = z_sample[11:4];
      `ACR_ADDR_Z_LOW: read_value = {z_sample[3:0], 4'h0};
      `ACR_ADDR_BUFFER_SETUP: read_value = BUFFER_SETUP;
      `ACR_ADDR_BUFFER_TRIGGER_MAP: read_value = BUFFER_TRIGGER_MAP;
      `ACR_ADDR_SYSTEM_MODE_NOW: read_value = {7'h00, active_q};
      `ACR_ADDR_INTERRUPT_SOURCE: read_value = int_source;
      `ACR_ADDR_DEVICE_IDENTITY: read_value = IDENTITY;
      `ACR_ADDR_RANGE_CONFIG: read_value = RANGE_CONFIG;
      `ACR_ADDR_HIGHPASS_CUTOFF: read_value = HIGHPASS_CUTOFF;
      `ACR_ADDR_ORIENTATION_STATE: read_value = orient_state;
      `ACR_ADDR_ORIENTATION_CONFIG: read_value = ORIENT_CONFIG;
      `ACR_ADDR_ORIENTATION_DEBOUNCE: read_value = ORIENT_DEBOUNCE;
      `ACR_ADDR_BACKFRONT_ZLOCK: read_value = BACKFRONT_ZLOCK;
      `ACR_ADDR_ORIENTATION_THS: read_value = ORIENT_THS;
      `ACR_ADDR_FALL_CONFIG: read_value = FALL_CONFIG;
      `ACR_ADDR_FALL_SOURCE: read_value = fall_source;
      `ACR_ADDR_FALL_THRESHOLD: read_value = FALL_THRESHOLD;
      `ACR_ADDR_FALL_DEBOUNCE: read_value = FALL_DEBOUNCE;
      default: read_value = 8'h00;
    endcase
  end

  // Read answer
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RD_DATA <= 8'h00;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= RD_STB;
      if (RD_STB) begin
        RD_DATA <= read_value;
      end
    end
  end

  // Byte position within the buffered sample
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      byte_idx <= 3'd0;
    end else if (STOP_DET || ADDR_LOAD || activate) begin
      byte_idx <= 3'd0;
    end else if (RD_STB && fifo_on && addr_ptr == `ACR_ADDR_X_HIGH && !fifo_empty) begin
      if (fifo_pop) begin
        byte_idx <= 3'd0;
      end else begin
        byte_idx <= 3'(byte_idx + (FAST_READ ? 3'd2 : 3'd1));
      end
    end
  end

  // Sample buffer pointers and status
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_count <= '0;
      fifo_overflow <= 1'b0;
    end else if (activate || !fifo_on) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_count <= '0;
      fifo_overflow <= 1'b0;
    end else begin
      if (fifo_push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (fifo_pop || fifo_drop_oldest) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      if (fifo_push && !fifo_pop && !fifo_drop_oldest) begin
        fifo_count <= (AW+1)'(fifo_count + 1'b1);
      end else if (fifo_pop && !fifo_push) begin
        fifo_count <= (AW+1)'(fifo_count - 1'b1);
      end
      if (SAMPLE_STB && fifo_full) begin
        fifo_overflow <= 1'b1;
      end
    end
  end

  // Real-time sample registers and status
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      x_sample <= 12'h000;
      y_sample <= 12'h000;
      z_sample <= 12'h000;
      rt_status <= 8'h00;
    end else if (activate) begin
      x_sample <= 12'h000;
      y_sample <= 12'h000;
      z_sample <= 12'h000;
      rt_status <= 8'h00;
    end else if (SAMPLE_STB) begin
      x_sample <= SAMPLE_X;
      y_sample <= SAMPLE_Y;
      z_sample <= SAMPLE_Z;
      rt_status[`ACR_STATUS_READY] <= 1'b1;
      if (rt_status[`ACR_STATUS_READY]) begin
        rt_status[`ACR_STATUS_OVERRUN] <= 1'b1;
      end
    end else if (RD_STB && !fifo_on && addr_ptr == `ACR_ADDR_Z_HIGH) begin
      rt_status <= 8'h00;
    end
  end

  // Event source registers
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      int_source <= 8'h00;
      orient_state <= 8'h00;
      fall_source <= 8'h00;
    end else if (activate) begin
      int_source <= 8'h00;
      orient_state <= 8'h00;
      fall_source <= 8'h00;
    end else if (SRC_STB) begin
      int_source <= INT_SOURCE_IN;
      orient_state <= ORIENT_STATE_IN;
      fall_source <= FALL_SOURCE_IN;
    end
  end

  // Configuration writes
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      BUFFER_SETUP <= `ACR_RESET_ZERO;
      BUFFER_TRIGGER_MAP <= `ACR_RESET_ZERO;
      RANGE_CONFIG <= `ACR_RESET_ZERO;
      HIGHPASS_CUTOFF <= `ACR_RESET_ZERO;
      ORIENT_CONFIG <= `ACR_RESET_ORIENTATION_CONFIG;
      ORIENT_DEBOUNCE <= `ACR_RESET_ZERO;
      BACKFRONT_ZLOCK <= `ACR_RESET_BACKFRONT_ZLOCK;
      ORIENT_THS <= `ACR_RESET_ORIENTATION_THS;
      FALL_CONFIG <= `ACR_RESET_ZERO;
      FALL_THRESHOLD <= `ACR_RESET_ZERO;
      FALL_DEBOUNCE <= `ACR_RESET_ZERO;
    end else if (WR_STB && !ADDR_LOAD && !STOP_DET && wr_ok) begin
      unique case (addr_ptr)
        `ACR_ADDR_BUFFER_SETUP: BUFFER_SETUP <= WR_DATA;
        `ACR_ADDR_BUFFER_TRIGGER_MAP: BUFFER_TRIGGER_MAP <= WR_DATA;
        `ACR_ADDR_RANGE_CONFIG: RANGE_CONFIG <= WR_DATA;
        `ACR_ADDR_HIGHPASS_CUTOFF: HIGHPASS_CUTOFF <= WR_DATA;
        `ACR_ADDR_ORIENTATION_CONFIG: ORIENT_CONFIG <= WR_DATA;
        `ACR_ADDR_ORIENTATION_DEBOUNCE: ORIENT_DEBOUNCE <= WR_DATA;
        `ACR_ADDR_BACKFRONT_ZLOCK: BACKFRONT_ZLOCK <= WR_DATA;
        `ACR_ADDR_ORIENTATION_THS: ORIENT_THS <= WR_DATA;
        `ACR_ADDR_FALL_CONFIG: FALL_CONFIG <= WR_DATA;
        `ACR_ADDR_FALL_THRESHOLD: FALL_THRESHOLD <= WR_DATA;
        `ACR_ADDR_FALL_DEBOUNCE: FALL_DEBOUNCE <= WR_DATA;
        default: ;
      endcase
    end
  end

  // Debounce restart pulses
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ORIENT_COUNT_CLR <= 1'b0;
      FALL_COUNT_CLR <= 1'b0;
    end else begin
      ORIENT_COUNT_CLR <= WR_STB && !ADDR_LOAD && !STOP_DET &&
                          addr_ptr == `ACR_ADDR_ORIENTATION_DEBOUNCE;
      FALL_COUNT_CLR <= WR_STB && !ADDR_LOAD && !STOP_DET &&
                        (addr_ptr == `ACR_ADDR_FALL_THRESHOLD ||
                         addr_ptr == `ACR_ADDR_FALL_DEBOUNCE);
    end
  end

endmodule : acr_regs

`default_nettype wire

/* File: sim/acr_regs_asserts.sv */
/*
 Concurrent checks on the ports of the lower accelerometer register bank.
 Assumes a bind onto acr_regs with every name matching a port.
*/
`timescale 1ns/1ps
`default_nettype none

module acr_regs_chk (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic ADDR_LOAD,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic STOP_DET,
  input wire logic ACTIVE_MODE,
  input wire logic [7:0] RD_DATA,
  input wire logic RD_VALID,
  input wire logic [7:0] BUFFER_SETUP,
  input wire logic [7:0] BUFFER_TRIGGER_MAP,
  input wire logic [7:0] RANGE_CONFIG,
  input wire logic [7:0] HIGHPASS_CUTOFF,
  input wire logic [7:0] ORIENT_CONFIG,
  input wire logic [7:0] ORIENT_DEBOUNCE,
  input wire logic [7:0] BACKFRONT_ZLOCK,
  input wire logic [7:0] ORIENT_THS,
  input wire logic [7:0] FALL_CONFIG,
  input wire logic [7:0] FALL_THRESHOLD,
  input wire logic [7:0] FALL_DEBOUNCE,
  input wire logic ORIENT_COUNT_CLR,
  input wire logic FALL_COUNT_CLR
);
  logic [47:0] standby_only;
  logic [87:0] all_cfg;
  assign standby_only = {BUFFER_TRIGGER_MAP, RANGE_CONFIG, ORIENT_CONFIG, BACKFRONT_ZLOCK,
                         ORIENT_THS, FALL_CONFIG};
  assign all_cfg = {standby_only, BUFFER_SETUP, HIGHPASS_CUTOFF, ORIENT_DEBOUNCE,
                    FALL_THRESHOLD, FALL_DEBOUNCE};

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);

  a_read_answer: assert property (RD_STB |=> RD_VALID)
    else $error("read strobe got no answer");
  a_no_extra_valid: assert property (!RD_STB |=> !RD_VALID)
    else $error("read answer without a read strobe");
  a_data_hold: assert property (!RD_VALID |-> $stable(RD_DATA))
    else $error("read data moved without an answer");
  a_cfg_by_write: assert property (!WR_STB |=> $stable(all_cfg))
    else $error("configuration changed without a write");
  a_standby_lock: assert property ($past(ACTIVE_MODE) && $past(RESETN) |=> $stable(standby_only))
    else $error("standby-only register changed while active");
  a_drop_write: assert property (WR_STB && (ADDR_LOAD || STOP_DET) |=>
    $stable(all_cfg) && !ORIENT_COUNT_CLR && !FALL_COUNT_CLR)
    else $error("write beside pointer load or stop took effect");
  a_orient_cause: assert property (ORIENT_COUNT_CLR |->
    $past(WR_STB) && !$past(ADDR_LOAD) && !$past(STOP_DET))
    else $error("orientation restart without a write");
  a_fall_cause: assert property (FALL_COUNT_CLR |-> $past(WR_STB) && !$past(STOP_DET))
    else $error("fall restart without a write");
  a_orient_single: assert property (ORIENT_COUNT_CLR |=> !ORIENT_COUNT_CLR)
    else $error("orientation restart longer than one cycle");

  c_read: cover property (RD_VALID);
  c_orient_clr: cover property (ORIENT_COUNT_CLR);
  c_fall_clr: cover property (FALL_COUNT_CLR);
  c_drop: cover property (WR_STB && STOP_DET);
endmodule : acr_regs_chk

`default_nettype wire

/* File: sim/acr_host_model.sv */
/*
 Host side of the register port: pointer loads, writes, reads and stops.
 Assumes the bench calls its tasks one at a time; drives at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module acr_host_model (
  input wire logic clk,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic addr_load,
  output logic [7:0] addr_in,
  output logic wr_stb,
  output logic [7:0] wr_data,
  output logic rd_stb,
  output logic stop_det
);
  initial begin
    addr_load = 1'b0;
    addr_in = 8'h00;
    wr_stb = 1'b0;
    wr_data = 8'h00;
    rd_stb = 1'b0;
    stop_det = 1'b0;
  end

  task automatic set_ptr(input logic [7:0] a);
    @(negedge clk);
    addr_load = 1'b1;
    addr_in = a;
    @(negedge clk);
    addr_load = 1'b0;
    addr_in = ~a;
  endtask : set_ptr

  task automatic wr(input logic [7:0] d);
    @(negedge clk);
    wr_stb = 1'b1;
    wr_data = d;
    @(negedge clk);
    wr_stb = 1'b0;
    wr_data = ~d;
  endtask : wr

  task automatic stop(input logic with_wr);
    @(negedge clk);
    stop_det = 1'b1;
    wr_stb = with_wr;
    wr_data = 8'h5a;
    @(negedge clk);
    stop_det = 1'b0;
    wr_stb = 1'b0;
    wr_data = 8'ha5;
  endtask : stop

  task automatic rd(output logic [7:0] d, output logic v);
    @(negedge clk);
    rd_stb = 1'b1;
    @(negedge clk);
    rd_stb = 1'b0;
    d = rd_data;
    v = rd_valid;
  endtask : rd
endmodule : acr_host_model

`default_nettype wire

/* File: sim/test_acr_regs.sv */
/*
 Self-checking bench of the lower register bank with its host model.
 Assumes acr_regs, acr_host_model and acr_regs_chk are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module test_acr_regs;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value
  logic CORE_CLK, RESETN, FAST_READ, ACTIVE_MODE, SAMPLE_STB, SRC_STB;
  logic ADDR_LOAD, WR_STB, RD_STB, STOP_DET, RD_VALID, ORIENT_COUNT_CLR, FALL_COUNT_CLR;
  logic [7:0] ADDR_IN, WR_DATA, RD_DATA, INT_SOURCE_IN, ORIENT_STATE_IN, FALL_SOURCE_IN;
  logic [7:0] BUFFER_SETUP, BUFFER_TRIGGER_MAP, RANGE_CONFIG, HIGHPASS_CUTOFF, ORIENT_CONFIG;
  logic [7:0] ORIENT_DEBOUNCE, BACKFRONT_ZLOCK, ORIENT_THS, FALL_CONFIG, FALL_THRESHOLD;
  logic [7:0] FALL_DEBOUNCE;
  logic [11:0] SAMPLE_X, SAMPLE_Y, SAMPLE_Z;
  int err_count = 0;
  int checked = 0;

  acr_regs #(.IDENTITY(ID)) acr_regs_i (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
    .ADDR_LOAD(ADDR_LOAD), .ADDR_IN(ADDR_IN), .WR_STB(WR_STB), .WR_DATA(WR_DATA),
    .RD_STB(RD_STB), .STOP_DET(STOP_DET), .FAST_READ(FAST_READ), .ACTIVE_MODE(ACTIVE_MODE),
    .SAMPLE_STB(SAMPLE_STB), .SAMPLE_X(SAMPLE_X), .SAMPLE_Y(SAMPLE_Y), .SAMPLE_Z(SAMPLE_Z),
    .SRC_STB(SRC_STB), .INT_SOURCE_IN(INT_SOURCE_IN), .ORIENT_STATE_IN(ORIENT_STATE_IN),
    .FALL_SOURCE_IN(FALL_SOURCE_IN), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
    .BUFFER_SETUP(BUFFER_SETUP), .BUFFER_TRIGGER_MAP(BUFFER_TRIGGER_MAP),
    .RANGE_CONFIG(RANGE_CONFIG), .HIGHPASS_CUTOFF(HIGHPASS_CUTOFF),
    .ORIENT_CONFIG(ORIENT_CONFIG), .ORIENT_DEBOUNCE(ORIENT_DEBOUNCE),
    .BACKFRONT_ZLOCK(BACKFRONT_ZLOCK), .ORIENT_THS(ORIENT_THS), .FALL_CONFIG(FALL_CONFIG),
    .FALL_THRESHOLD(FALL_THRESHOLD), .FALL_DEBOUNCE(FALL_DEBOUNCE),
    .ORIENT_COUNT_CLR(ORIENT_COUNT_CLR), .FALL_COUNT_CLR(FALL_COUNT_CLR));
  acr_host_model acr_host_model_i (.clk(CORE_CLK), .rd_data(RD_DATA), .rd_valid(RD_VALID),
    .addr_load(ADDR_LOAD), .addr_in(ADDR_IN), .wr_stb(WR_STB), .wr_data(WR_DATA),
    .rd_stb(RD_STB), .stop_det(STOP_DET));

  initial CORE_CLK = 1'b0;
  always #2.5 CORE_CLK = ~CORE_CLK;

  task automatic complete_run;
    $display("Counts: checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Reads one byte and compares it and its answer strobe
  task automatic rx(input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    acr_host_model_i.rd(d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask : rx

  task automatic sample(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
    @(negedge CORE_CLK);
    SAMPLE_STB = 1'b1;
    SAMPLE_X = x;
    SAMPLE_Y = y;
    SAMPLE_Z = z;
    @(negedge CORE_CLK);
    SAMPLE_STB = 1'b0;
    @(negedge CORE_CLK);
  endtask : sample

  task automatic mode(input logic a);
    @(negedge CORE_CLK);
    ACTIVE_MODE = a;
    repeat (2) @(negedge CORE_CLK);
  endtask : mode

  task automatic t_reset;
    logic [7:0] e;
    acr_host_model_i.set_ptr(8'h07);
    for (int a = 8'h07; a <= 8'h1c; a++) begin
      e = (a == 8'h0d) ? ID : (a == 8'h11) ? 8'h80 : (a == 8'h13) ? 8'h44 :
          (a == 8'h14) ? 8'h84 : 8'h00;
      rx(e);
    end
    $display("reset map test done");
  endtask : t_reset

  task automatic t_burst;
    logic [7:0] exp [8] = '{8'h08, 8'hab, 8'hc0, 8'h12, 8'h30, 8'h9f, 8'h50, 8'h00};
    sample(12'habc, 12'h123, 12'h9f5);
    acr_host_model_i.set_ptr(8'h00);
    foreach (exp[i]) rx(exp[i]);
    $display("burst test done");
  endtask : t_burst

  task automatic t_fast;
    logic [7:0] hi [5] = '{8'hab, 8'h12, 8'h9f, 8'h00, 8'hab};
    logic [7:0] lo [3] = '{8'hc0, 8'h30, 8'h50};
    FAST_READ = 1'b1;
    acr_host_model_i.set_ptr(8'h01);
    foreach (hi[i]) rx(hi[i]);
    for (int i = 0; i < 3; i++) begin
      acr_host_model_i.set_ptr(8'(2 + 2 * i));
      rx(lo[i]);
      rx(8'h00);
    end
    FAST_READ = 1'b0;
    $display("fast read test done");
  endtask : t_fast

  task automatic t_stop;
    sample(12'habc, 12'h123, 12'h9f5);
    acr_host_model_i.set_ptr(8'h12);
    acr_host_model_i.stop(1'b1);
    chk(ORIENT_DEBOUNCE, 8'h00);
    rx(8'h08);
    $display("stop test done");
  endtask : t_stop

  task automatic t_write;
    acr_host_model_i.set_ptr(8'h11);
    acr_host_model_i.wr(8'h55);
    acr_host_model_i.wr(8'h07);
    chk({7'h00, ORIENT_COUNT_CLR}, 8'h01);
    chk(ORIENT_CONFIG, 8'h55);
    acr_host_model_i.set_ptr(8'h07);
    acr_host_model_i.wr(8'hff);
    acr_host_model_i.set_ptr(8'h07);
    rx(8'h00);
    mode(1'b1);
    acr_host_model_i.set_ptr(8'h11);
    acr_host_model_i.wr(8'h22);
    chk(ORIENT_CONFIG, 8'h55);
    acr_host_model_i.set_ptr(8'h17);
    acr_host_model_i.wr(8'h09);
    chk({7'h00, FALL_COUNT_CLR}, 8'h01);
    chk(FALL_THRESHOLD, 8'h09);
    $display("write test done");
  endtask : t_write

  task automatic t_active;
    sample(12'h456, 12'h789, 12'hdef);
    @(negedge CORE_CLK);
    SRC_STB = 1'b1;
    INT_SOURCE_IN = 8'h21;
    ORIENT_STATE_IN = 8'h42;
    FALL_SOURCE_IN = 8'h84;
    @(negedge CORE_CLK);
    SRC_STB = 1'b0;
    mode(1'b0);
    acr_host_model_i.set_ptr(8'h00);
    rx(8'h08);
    rx(8'h45);
    acr_host_model_i.set_ptr(8'h0b);
    rx(8'h00);
    rx(8'h21);
    mode(1'b1);
    acr_host_model_i.set_ptr(8'h00);
    rx(8'h00);
    rx(8'h00);
    acr_host_model_i.set_ptr(8'h0b);
    rx(8'h01);
    rx(8'h00);
    $display("mode change test done");
  endtask : t_active

  task automatic t_fifo;
    logic [7:0] d;
    logic v;
    logic [7:0] exp [12] = '{8'h11, 8'h10, 8'h22, 8'h20, 8'h33, 8'h30,
                             8'h44, 8'h40, 8'h55, 8'h50, 8'h66, 8'h60};
    acr_host_model_i.set_ptr(8'h09);
    acr_host_model_i.wr(8'h42);
    sample(12'h111, 12'h222, 12'h333);
    sample(12'h444, 12'h555, 12'h666);
    acr_host_model_i.set_ptr(8'h00);
    rx(8'h42);
    foreach (exp[i]) rx(exp[i]);
    FAST_READ = 1'b1;
    acr_host_model_i.set_ptr(8'h03);
    acr_host_model_i.rd(d, v);
    rx(8'h00);
    FAST_READ = 1'b0;
    acr_host_model_i.set_ptr(8'h09);
    acr_host_model_i.wr(8'h00);
    $display("buffer test done");
  endtask : t_fifo

  initial begin
    repeat (20000) @(posedge CORE_CLK);
    err_count++;
    complete_run;
  end

  initial begin
    RESETN = 1'b0;
    FAST_READ = 1'b0;
    ACTIVE_MODE = 1'b0;
    SAMPLE_STB = 1'b0;
    SRC_STB = 1'b0;
    SAMPLE_X = 12'h000;
    SAMPLE_Y = 12'h000;
    SAMPLE_Z = 12'h000;
    INT_SOURCE_IN = 8'h00;
    ORIENT_STATE_IN = 8'h00;
    FALL_SOURCE_IN = 8'h00;
    repeat (16) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    RESETN = 1'b1;
    t_reset;
    t_burst;
    t_fast;
    t_stop;
    t_write;
    t_active;
    t_fifo;
    complete_run;
  end
endmodule : test_acr_regs

bind acr_regs acr_regs_chk acr_regs_chk_i (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
  .ADDR_LOAD(ADDR_LOAD), .WR_STB(WR_STB), .RD_STB(RD_STB), .STOP_DET(STOP_DET),
  .ACTIVE_MODE(ACTIVE_MODE), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
  .BUFFER_SETUP(BUFFER_SETUP), .BUFFER_TRIGGER_MAP(BUFFER_TRIGGER_MAP),
  .RANGE_CONFIG(RANGE_CONFIG), .HIGHPASS_CUTOFF(HIGHPASS_CUTOFF),
  .ORIENT_CONFIG(ORIENT_CONFIG), .ORIENT_DEBOUNCE(ORIENT_DEBOUNCE),
  .BACKFRONT_ZLOCK(BACKFRONT_ZLOCK), .ORIENT_THS(ORIENT_THS), .FALL_CONFIG(FALL_CONFIG),
  .FALL_THRESHOLD(FALL_THRESHOLD), .FALL_DEBOUNCE(FALL_DEBOUNCE),
  .ORIENT_COUNT_CLR(ORIENT_COUNT_CLR), .FALL_COUNT_CLR(FALL_COUNT_CLR));

`default_nettype wire
